/* rtl/pbe_consts.svh */
// Constants for the port B / port E pin assignment block.
// Overview of operation
// - Expanded and peripheral modes put address/data low byte on port B; narrow: address only.
// - Port B data and direction leave the map in expanded and peripheral modes.
// - Direction bit 0 makes pin input, 1 output; direction registers reset to zero.
// - Port E pins are general I/O unless assignment selects their alternate function.
// - Alternate function overrides the pin's direction bit.
// - One bit enables pull-ups on pins 7,3,2,1,0 only while they are inputs.
// - Port E data/direction leave the map in peripheral, or expanded with emulation set.
// - Pins 1 and 0 are input only, direction reads 0, levels always readable.
// - Assignment register reset value depends on operating mode.
// - Peripheral mode hides assignment register; clock-test resets set, pin 6 shows test clock.
// - Bus fields write once in normal modes; special modes ignore first write only.
// - Clear no-data-bus-enable in expanded modes gives data enable or inverted E on pin 7.
// - Clock-test never writable in normal modes; pin 6 test output; pipe enable overrides.
// - Pipe enable in expanded modes makes pins 6 and 5 queue status outputs.
// - No-E-clock write once normal single-chip, anytime special single-chip, else never.
// - No-E-clock 0 drives E on pin 4 (an input in peripheral mode); single-chip also needs stretch 0.
// - Low-strobe enable drives pin 3 except single-chip and normal expanded narrow; in peripheral mode pin 3 is an input.
// - Special expanded with low strobe and tagging samples pin 3 at E falling edge.
// - Read/write enable drives pin 2 in expanded modes only.
// - Data-enable select picks data enable (0) or inverted E (1) on pin 7.
// - Calibration enable drives pin 7 in single-chip, peripheral, or no-data-bus-enable set.
`ifndef PBE_CONSTS_SVH
`define PBE_CONSTS_SVH
`define PBE_ADDR_W 8
`define PBE_OFS_PORT_B_DATA 8'h01
`define PBE_OFS_PORT_B_DIR 8'h03
`define PBE_OFS_PORT_E_DATA 8'h08
`define PBE_OFS_PORT_E_DIR 8'h09
`define PBE_OFS_PORT_E_PIN_ASSIGNMENT 8'h0A
`define PBE_OFS_PULLUP 8'h0C
`define PBE_OFS_STATUS 8'h0E
`define PBE_BIT_NO_DATA_BUS_EN 7
`define PBE_BIT_CLOCK_TEST 6
`define PBE_BIT_PIPE_STATUS 5
`define PBE_BIT_NO_E_CLOCK 4
`define PBE_BIT_LOW_STROBE 3
`define PBE_BIT_READ_WRITE 2
`define PBE_BIT_CALIBRATION 1
`define PBE_BIT_DATA_ENABLE_SEL 0
`define PBE_ONCE_MASK 8'hAD
`define PBE_DIR_E_MASK 8'hFC
`define PBE_PULL_MASK 8'h8F
`define PBE_RST_NORM_EXP 8'h00
`define PBE_RST_SPECIAL 8'h2C
`define PBE_RST_PERIPH 8'hD0
`define PBE_RST_NORM_SC 8'h90
`define PBE_RST_PULLUP 8'h01
`endif

/* rtl/pbe_pkg.sv */
// Types for the port B / port E pin assignment block.
package pbe_pkg;
  typedef enum logic [2:0] {
    PBE_NORM_SC,
    PBE_NORM_EXP_NARROW,
    PBE_PERIPH,
    PBE_NORM_EXP_WIDE,
    PBE_SPEC_SC,
    PBE_SPEC_EXP_NARROW,
    PBE_SPEC_TEST,
    PBE_SPEC_EXP_WIDE
  } pbe_mode_t;
endpackage

/* rtl/pbe_port_mux.sv */
// Port B and port E registers, pin assignment and pin multiplexing.
`timescale 1ns/1ps
`include "pbe_consts.svh"
module pbe_port_mux
  import pbe_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] mode,
  input wire logic emulate_port_e,
  input wire logic e_clock_stretch,
  input wire logic tag_enable,
  input wire logic [`PBE_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic ext_access,
  input wire logic [7:0] bus_addr_lo,
  input wire logic [7:0] bus_wdata_lo,
  input wire logic bus_drive_data,
  input wire logic e_clock,
  input wire logic data_enable_n,
  input wire logic low_strobe_n,
  input wire logic read_write,
  input wire logic [1:0] pipe_status,
  input wire logic clock_test,
  input wire logic calibration_ref,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  input wire logic [7:0] port_e_in,
  output logic [7:0] port_e_out,
  output logic [7:0] port_e_oe,
  output logic [7:0] port_e_pull,
  output logic tag_low_byte
);

  pbe_mode_t mode_reg;
  logic [7:0] pb_data_reg;
  logic [7:0] pb_dir_reg;
  logic [7:0] pe_data_reg;
  logic [7:0] pe_dir_reg;
  logic [7:0] port_e_pin_assignment_reg;
  logic [7:0] port_e_pin_assignment_next;
  logic [7:0] pullup_reg;
  logic written_reg;
  logic no_e_clock_written_reg;
  logic [7:0] pb_sync1_reg;
  logic [7:0] pb_sync2_reg;
  logic [7:0] pe_sync1_reg;
  logic [7:0] pe_sync2_reg;
  logic e_prev_reg;
  logic [7:0] pe_sel;
  logic [7:0] pe_alt_val;
  logic [7:0] pe_alt_oe;
  logic [7:0] pe_out_next;
  logic [7:0] pe_oe_next;
  logic [7:0] rdata_next;
  logic is_special;
  logic is_sc;
  logic is_exp;
  logic is_periph;
  logic is_norm_narrow;
  logic pb_mapped;
  logic pe_mapped;
  logic port_e_pin_assignment_mapped;
  logic hit;

  // Mode is sampled once after reset release; the straps are static afterwards.
  logic mode_taken_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= PBE_NORM_SC;
      mode_taken_reg <= 1'b0;
    end else if (!mode_taken_reg) begin
      mode_reg <= pbe_mode_t'(mode);
      mode_taken_reg <= 1'b1;
    end
  end

  // Mode decode.
  assign is_special = (mode_reg == PBE_SPEC_SC) || (mode_reg == PBE_SPEC_EXP_NARROW) ||
                      (mode_reg == PBE_SPEC_TEST) || (mode_reg == PBE_SPEC_EXP_WIDE);
  assign is_sc = (mode_reg == PBE_NORM_SC) || (mode_reg == PBE_SPEC_SC);
  assign is_periph = (mode_reg == PBE_PERIPH);
  assign is_exp = !is_sc && !is_periph;
  assign is_norm_narrow = (mode_reg == PBE_NORM_EXP_NARROW);

  // Map removal for the expansion registers.
  assign pb_mapped = is_sc;
  assign pe_mapped = is_sc || (is_exp && !emulate_port_e);
  assign port_e_pin_assignment_mapped = !is_periph;

  // Pin inputs cross into the clock domain through two flip-flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pb_sync1_reg <= 8'h00;
      pb_sync2_reg <= 8'h00;
      pe_sync1_reg <= 8'h00;
      pe_sync2_reg <= 8'h00;
    end else begin
      pb_sync1_reg <= port_b_in;
      pb_sync2_reg <= pb_sync1_reg;
      pe_sync1_reg <= port_e_in;
      pe_sync2_reg <= pe_sync1_reg;
    end
  end

  // Port B data and direction registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pb_data_reg <= 8'h00;
      pb_dir_reg <= 8'h00;
    end else if (wr && pb_mapped) begin
      if (addr == `PBE_OFS_PORT_B_DATA) pb_data_reg <= wdata;
      if (addr == `PBE_OFS_PORT_B_DIR) pb_dir_reg <= wdata;
    end
  end

  // Port E data, direction and pull-up control registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pe_data_reg <= 8'h00;
      pe_dir_reg <= 8'h00;
      pullup_reg <= `PBE_RST_PULLUP;
    end else if (wr) begin
      if (pe_mapped && addr == `PBE_OFS_PORT_E_DATA) pe_data_reg <= wdata;
      if (pe_mapped && addr == `PBE_OFS_PORT_E_DIR) pe_dir_reg <= wdata & `PBE_DIR_E_MASK;
      if (!is_periph && addr == `PBE_OFS_PULLUP) pullup_reg <= {7'h00, wdata[0]};
    end
  end

  // Write policy of the assignment register, field by field.
  always_comb begin
    port_e_pin_assignment_next = port_e_pin_assignment_reg;
    // Calibration enable is writable anytime.
    port_e_pin_assignment_next[`PBE_BIT_CALIBRATION] = wdata[`PBE_BIT_CALIBRATION];
    if (is_special) begin
      if (written_reg) begin
        port_e_pin_assignment_next = (port_e_pin_assignment_next & ~`PBE_ONCE_MASK) | (wdata & `PBE_ONCE_MASK);
        port_e_pin_assignment_next[`PBE_BIT_CLOCK_TEST] = wdata[`PBE_BIT_CLOCK_TEST];
      end
    end else if (!written_reg) begin
      port_e_pin_assignment_next = (port_e_pin_assignment_next & ~`PBE_ONCE_MASK) | (wdata & `PBE_ONCE_MASK);
    end
    // No-E-clock has its own policy, tied only to single-chip modes.
    if (mode_reg == PBE_SPEC_SC) begin
      port_e_pin_assignment_next[`PBE_BIT_NO_E_CLOCK] = wdata[`PBE_BIT_NO_E_CLOCK];
    end else if (mode_reg == PBE_NORM_SC && !no_e_clock_written_reg) begin
      port_e_pin_assignment_next[`PBE_BIT_NO_E_CLOCK] = wdata[`PBE_BIT_NO_E_CLOCK];
    end else begin
      port_e_pin_assignment_next[`PBE_BIT_NO_E_CLOCK] = port_e_pin_assignment_reg[`PBE_BIT_NO_E_CLOCK];
    end
  end

  // The assignment register resets per mode; the value is loaded once the mode is known.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_e_pin_assignment_reg <= `PBE_RST_NORM_SC;
      written_reg <= 1'b0;
      no_e_clock_written_reg <= 1'b0;
    end else if (!mode_taken_reg) begin
      unique case (pbe_mode_t'(mode))
        PBE_NORM_EXP_NARROW, PBE_NORM_EXP_WIDE: port_e_pin_assignment_reg <= `PBE_RST_NORM_EXP;
        PBE_PERIPH: port_e_pin_assignment_reg <= `PBE_RST_PERIPH;
        PBE_NORM_SC: port_e_pin_assignment_reg <= `PBE_RST_NORM_SC;
        default: port_e_pin_assignment_reg <= `PBE_RST_SPECIAL;
      endcase
    end else if (wr && port_e_pin_assignment_mapped && addr == `PBE_OFS_PORT_E_PIN_ASSIGNMENT) begin
      port_e_pin_assignment_reg <= port_e_pin_assignment_next;
      written_reg <= 1'b1;
      if (mode_reg == PBE_NORM_SC) no_e_clock_written_reg <= 1'b1;
    end
  end

  // Alternate function selection and values for each port E pin.
  always_comb begin
    pe_sel = 8'h00;
    pe_alt_val = 8'h00;
    pe_alt_oe = 8'h00;
    // Pin 7: data enable, inverted E or calibration reference.
    if (is_exp && !port_e_pin_assignment_reg[`PBE_BIT_NO_DATA_BUS_EN]) begin
      pe_sel[7] = 1'b1;
      pe_alt_oe[7] = 1'b1;
      pe_alt_val[7] = port_e_pin_assignment_reg[`PBE_BIT_DATA_ENABLE_SEL] ? !e_clock : data_enable_n;
    end else if (port_e_pin_assignment_reg[`PBE_BIT_CALIBRATION]) begin
      pe_sel[7] = 1'b1;
      pe_alt_oe[7] = 1'b1;
      pe_alt_val[7] = calibration_ref;
    end
    // Pins 6 and 5: pipe status, with clock test on pin 6 as the weaker choice.
    if (is_exp && port_e_pin_assignment_reg[`PBE_BIT_PIPE_STATUS]) begin
      pe_sel[6:5] = 2'b11;
      pe_alt_oe[6:5] = 2'b11;
      pe_alt_val[6:5] = pipe_status;
    end else if (port_e_pin_assignment_reg[`PBE_BIT_CLOCK_TEST] && !is_sc && mode_reg != PBE_NORM_EXP_NARROW &&
                 mode_reg != PBE_NORM_EXP_WIDE) begin
      pe_sel[6] = 1'b1;
      pe_alt_oe[6] = 1'b1;
      pe_alt_val[6] = clock_test;
    end
    // Pin 4: E clock, an input in peripheral mode.
    if (!port_e_pin_assignment_reg[`PBE_BIT_NO_E_CLOCK] && !(is_sc && e_clock_stretch)) begin
      pe_sel[4] = 1'b1;
      pe_alt_oe[4] = !is_periph;
      pe_alt_val[4] = e_clock;
    end
    // Pin 3: low strobe.
    if (port_e_pin_assignment_reg[`PBE_BIT_LOW_STROBE] && !is_sc && !is_norm_narrow) begin
      pe_sel[3] = 1'b1;
      pe_alt_oe[3] = !is_periph;
      pe_alt_val[3] = low_strobe_n;
    end
    // Pin 2: read/write.
    if (port_e_pin_assignment_reg[`PBE_BIT_READ_WRITE] && is_exp) begin
      pe_sel[2] = 1'b1;
      pe_alt_oe[2] = 1'b1;
      pe_alt_val[2] = read_write;
    end
    // Pins 1 and 0 are interrupt inputs and never drive.
    pe_sel[1:0] = 2'b11;
  end

  // Output drive: alternate function wins over the direction bit.
  assign pe_out_next = (pe_sel & pe_alt_val) | (~pe_sel & pe_data_reg);
  assign pe_oe_next = (pe_sel & pe_alt_oe) | (~pe_sel & pe_dir_reg);

  // Pin outputs come straight from flip-flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_b_out <= 8'h00;
      port_b_oe <= 8'h00;
      port_e_out <= 8'h00;
      port_e_oe <= 8'h00;
      port_e_pull <= 8'h00;
    end else begin
      if (is_sc) begin
        port_b_out <= pb_data_reg;
        port_b_oe <= pb_dir_reg;
      end else begin
        // Narrow buses carry only the address on port B.
        port_b_out <= (bus_drive_data && !is_norm_narrow && mode_reg != PBE_SPEC_EXP_NARROW)
                      ? bus_wdata_lo : bus_addr_lo;
        port_b_oe <= (bus_drive_data || !e_clock) ? 8'hFF : 8'h00;
      end
      port_e_out <= pe_out_next;
      port_e_oe <= pe_oe_next;
      // Pull-ups only act on listed pins while they are inputs.
      port_e_pull <= (pullup_reg[0] ? `PBE_PULL_MASK : 8'h00) & ~pe_oe_next;
    end
  end

  // Tag sampling of pin 3 at the falling edge of E.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      e_prev_reg <= 1'b0;
      tag_low_byte <= 1'b0;
    end else begin
      e_prev_reg <= e_clock;
      tag_low_byte <= e_prev_reg && !e_clock && tag_enable && port_e_pin_assignment_reg[`PBE_BIT_LOW_STROBE] &&
                      (mode_reg == PBE_SPEC_EXP_NARROW || mode_reg == PBE_SPEC_EXP_WIDE) &&
                      !pe_sync2_reg[3];
    end
  end

  // Read decode; unmapped or removed registers read zero and flag an external access.
  always_comb begin
    rdata_next = 8'h00;
    hit = 1'b1;
    unique case (addr)
      `PBE_OFS_PORT_B_DATA: begin
        hit = pb_mapped;
        rdata_next = pb_mapped ? ((pb_dir_reg & pb_data_reg) | (~pb_dir_reg & pb_sync2_reg))
                               : 8'h00;
      end
      `PBE_OFS_PORT_B_DIR: begin
        hit = pb_mapped;
        rdata_next = pb_mapped ? pb_dir_reg : 8'h00;
      end
      `PBE_OFS_PORT_E_DATA: begin
        hit = pe_mapped;
        rdata_next = pe_mapped ? ((pe_oe_next & ~pe_sel & pe_data_reg) |
                                  ~(pe_oe_next & ~pe_sel) & pe_sync2_reg) : 8'h00;
      end
      `PBE_OFS_PORT_E_DIR: begin
        hit = pe_mapped;
        rdata_next = pe_mapped ? pe_dir_reg : 8'h00;
      end
      `PBE_OFS_PORT_E_PIN_ASSIGNMENT: begin
        hit = port_e_pin_assignment_mapped;
        rdata_next = port_e_pin_assignment_mapped ? port_e_pin_assignment_reg : 8'h00;
      end
      `PBE_OFS_PULLUP: begin
        hit = !is_periph;
        rdata_next = is_periph ? 8'h00 : pullup_reg;
      end
      `PBE_OFS_STATUS: rdata_next = {written_reg, no_e_clock_written_reg, 3'h0, mode_reg};
      default: hit = 1'b0;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      ext_access <= 1'b0;
    end else begin
      rdata <= rd ? rdata_next : 8'h00;
      ext_access <= (rd || wr) && !hit;
    end
  end

  // Direction of pins 1 and 0 never reads as one.
  a_dir_low_zero: assert property (@(posedge clock) disable iff (!rst_n)
    pe_dir_reg[1:0] == 2'b00) else $error("interrupt pin direction set");

  // Interrupt pins never drive.
  a_irq_no_drive: assert property (@(posedge clock) disable iff (!rst_n)
    port_e_oe[1:0] == 2'b00) else $error("interrupt pin driven");

  // Port B direction writes are ignored when removed from the map.
  a_pb_unmapped: assert property (@(posedge clock) disable iff (!rst_n)
    (wr && !pb_mapped && mode_taken_reg) |=> $stable(pb_dir_reg))
    else $error("port B direction changed while unmapped");

  // Normal modes accept only one write to the bus fields.
  a_once_normal: assert property (@(posedge clock) disable iff (!rst_n)
    (wr && addr == `PBE_OFS_PORT_E_PIN_ASSIGNMENT && !is_special && written_reg && mode_taken_reg)
    |=> ((port_e_pin_assignment_reg & `PBE_ONCE_MASK) == ($past(port_e_pin_assignment_reg) & `PBE_ONCE_MASK)))
    else $error("normal mode bus field rewritten");

  // Clock-test bit never changes by write in normal modes.
  a_clock_test_normal: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_taken_reg && $past(mode_taken_reg) && !is_special)
    |-> $stable(port_e_pin_assignment_reg[`PBE_BIT_CLOCK_TEST]))
    else $error("clock test bit written in normal mode");

  // Read/write pin is general I/O in single-chip modes.
  a_rdw_sc: assert property (@(posedge clock) disable iff (!rst_n)
    (is_sc && mode_taken_reg) |=> (port_e_oe[2] == $past(pe_dir_reg[2])))
    else $error("read/write driven in single chip");

  // Pull-up never on a driving pin.
  a_pull_input: assert property (@(posedge clock) disable iff (!rst_n)
    (port_e_pull & port_e_oe) == 8'h00) else $error("pull-up on output pin");

  // Read data appear only the cycle after a read strobe.
  a_read_timing: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(rd) |-> rdata == 8'h00) else $error("read data outside read slot");

endmodule

/* tb/pbe_pin_partner.sv */
// Pin-side model of the external memories and peripherals on ports B and E.
`timescale 1ns/1ps
module pbe_pin_partner (
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe,
  input wire logic [7:0] port_e_out,
  input wire logic [7:0] port_e_oe,
  input wire logic [7:0] port_e_pull,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] ext_e,
  input wire logic [7:0] ext_e_drive,
  output logic [7:0] port_b_in,
  output logic [7:0] port_b_oe_seen,
  output logic [7:0] port_e_in
);
  // A driven pin shows the block's level; a released one shows the far side's level.
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & ext_b);
  assign port_b_oe_seen = port_b_oe;
  // A driven far side sets a released pin; a floating one reads high under a pull-up.
  // Without a pull-up a floating pin drifts away from the last level the block drove.
  assign port_e_in = (port_e_oe & port_e_out) | (~port_e_oe & ((ext_e_drive & ext_e) |
                     (~ext_e_drive & (port_e_pull | ~port_e_out))));
endmodule

/* tb/port_b_e_bus_pin_assignment_tb.sv */
// Self-checking bench for the port B / port E pin assignment block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module port_b_e_bus_pin_assignment_tb;
  import pbe_pkg::*;
  logic clock, rst_n, emulate_port_e, e_clock_stretch, tag_enable, wr, rd;
  logic [2:0] mode;
  logic [7:0] addr, wdata, rdata, bus_addr_lo, bus_wdata_lo, port_b_in, port_b_out, port_b_oe;
  logic [7:0] port_e_in, port_e_out, port_e_oe, port_e_pull, ext_b, ext_e, v, d, b, pm;
  logic bus_drive_data, e_clock, data_enable_n, low_strobe_n, read_write, clock_test;
  logic calibration_ref, ext_access, tag_low_byte, e;
  logic [1:0] pipe_status;
  logic [7:0] ext_e_drive;
  logic [31:0] lf;
  int n_errors, checks_done;

  pbe_port_mux dut (.clock(clock), .rst_n(rst_n), .mode(mode), .emulate_port_e(emulate_port_e),
    .e_clock_stretch(e_clock_stretch), .tag_enable(tag_enable), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ext_access(ext_access), .bus_addr_lo(bus_addr_lo),
    .bus_wdata_lo(bus_wdata_lo), .bus_drive_data(bus_drive_data), .e_clock(e_clock),
    .data_enable_n(data_enable_n), .low_strobe_n(low_strobe_n), .read_write(read_write),
    .pipe_status(pipe_status), .clock_test(clock_test), .calibration_ref(calibration_ref),
    .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
    .port_e_in(port_e_in), .port_e_out(port_e_out), .port_e_oe(port_e_oe),
    .port_e_pull(port_e_pull), .tag_low_byte(tag_low_byte));
  pbe_pin_partner pins (.port_b_out(port_b_out), .port_b_oe(port_b_oe), .port_e_out(port_e_out),
    .port_e_oe(port_e_oe), .port_e_pull(port_e_pull), .ext_b(ext_b), .ext_e(ext_e),
    .ext_e_drive(ext_e_drive),
    .port_b_in(port_b_in), .port_b_oe_seen(), .port_e_in(port_e_in));

  // Free-running system clock.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Pseudo-random source; a fixed start keeps runs repeatable.
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction

  // Per-mode reset value of the assignment register.
  function automatic logic [7:0] rst_val(input int m);
    case (m)
      0: return 8'h90;
      1, 3: return 8'h00;
      2: return 8'hD0;
      default: return 8'h2C;
    endcase
  endfunction

  // Reference model of one write to the assignment register.
  function automatic logic [7:0] port_e_pin_assignment_after(input int m, input bit first, input logic [7:0] old,
                                            input logic [7:0] dv);
    logic [7:0] mask;
    mask = 8'h02;
    if (m >= 4) begin
      if (!first) mask = mask | 8'hED;
      if (m == 4) mask = mask | 8'h10;
    end else if (first) begin
      mask = mask | 8'hAD;
      if (m == 0) mask = mask | 8'h10;
    end
    return (old & ~mask) | (dv & mask);
  endfunction

  task automatic go_reset(input logic [2:0] md);
    rst_n <= 1'b0;
    mode <= md;
    emulate_port_e <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clock);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Read data and the external-access pulse stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] rv, output logic re);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    rv = rdata;
    re = ext_access;
  endtask

  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence.
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end

  // Main sequence.
  initial begin
    n_errors = 0;
    checks_done = 0;
    lf = 32'hB02EA787;
    {wr, rd, e_clock_stretch, tag_enable, calibration_ref, emulate_port_e} = 6'h00;
    {bus_drive_data, e_clock, data_enable_n, low_strobe_n, read_write, clock_test} = 6'h00;
    {addr, wdata, pipe_status, mode, rst_n} = 22'h000000;
    bus_addr_lo = rnd();
    bus_wdata_lo = rnd();
    ext_b = rnd();
    ext_e = 8'h00;
    ext_e_drive = 8'hFF;
    // Every mode: map removal; reset value and the write policy (once in normal, first ignored in special) in every mode but peripheral.
    for (int m = 0; m < 8; m++) begin
      go_reset(m[2:0]);
      rd_reg(8'h0A, v, e);
      if (m == 2) `CHK("port_e_pin_assignment hidden", 1'b1, e)
      else `CHK("port_e_pin_assignment reset", rst_val(m), v)
      rd_reg(8'h01, v, e);
      `CHK("port b map", (m != 0 && m != 4), e)
      rd_reg(8'h08, v, e);
      `CHK("port e map", (m == 2), e)
      if (m != 2) begin
        pm = rst_val(m);
        for (int k = 0; k < 2; k++) begin
          d = rnd();
          wr_reg(8'h0A, d);
          pm = port_e_pin_assignment_after(m, k == 0, pm, d);
          rd_reg(8'h0A, v, e);
          `CHK("port_e_pin_assignment write", pm, v)
        end
      end
    end
    // Normal single chip: general-purpose directions, pull-ups and input-only pins.
    go_reset(3'd0);
    `CHK("pull all inputs", 8'h8F, port_e_pull)
    wr_reg(8'h09, 8'hFF);
    rd_reg(8'h09, v, e);
    `CHK("dir e readback", 8'hFC, v)
    ext_e <= rnd();
    repeat (4) @(posedge clock);
    `CHK("port e oe", 8'hFC, port_e_oe)
    `CHK("pull inputs only", 8'h03, port_e_pull)
    rd_reg(8'h08, v, e);
    `CHK("pe low pins", ext_e[1:0], v[1:0])
    // Let the far side float on the interrupt pins: the pull-ups must lift them.
    ext_e_drive <= 8'hFC;
    repeat (4) @(posedge clock);
    rd_reg(8'h08, v, e);
    `CHK("pe pulled low pins", 2'b11, v[1:0])
    ext_e_drive <= 8'hFF;
    d = rnd();
    b = rnd();
    wr_reg(8'h03, d);
    wr_reg(8'h01, b);
    repeat (3) @(posedge clock);
    `CHK("port b oe", d, port_b_oe)
    `CHK("port b out", b & d, port_b_out & d)
    rd_reg(8'h03, v, e);
    `CHK("dir b readback", d, v)
    rd_reg(8'h01, v, e);
    `CHK("port b readback", (b & d) | (~d & ext_b), v)
    // Normal expanded wide: bus pins, then enable strobe and read/write.
    go_reset(3'd3);
    {e_clock, data_enable_n, low_strobe_n, read_write, bus_drive_data} <= 5'b10011;
    repeat (3) @(posedge clock);
    `CHK("pe7 pe4 driven", 2'b11, {port_e_oe[7], port_e_oe[4]})
    `CHK("pe7 pe4 level", 2'b01, {port_e_out[7], port_e_out[4]})
    `CHK("pe3 pe2 off", 2'b00, port_e_oe[3:2])
    `CHK("port b data", bus_wdata_lo, port_b_out)
    `CHK("port b bus oe", 8'hFF, port_b_oe)
    data_enable_n <= 1'b1;
    wr_reg(8'h0A, 8'h0D);
    repeat (3) @(posedge clock);
    `CHK("pe3 pe2 on", 2'b11, port_e_oe[3:2])
    `CHK("pe3 pe2 level", 2'b01, port_e_out[3:2])
    `CHK("pe7 inv e", 1'b0, port_e_out[7])
    emulate_port_e <= 1'b1;
    rd_reg(8'h08, v, e);
    `CHK("emulated port e", 1'b1, e)
    // Peripheral: test clock on pin 6, E pin is an input.
    go_reset(3'd2);
    clock_test <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("pe6 test", 2'b11, {port_e_oe[6], port_e_out[6]})
    `CHK("e pin input", 1'b0, port_e_oe[4])
    // Special expanded wide: queue status overrides the direction bits.
    go_reset(3'd7);
    pipe_status <= 2'b10;
    repeat (3) @(posedge clock);
    `CHK("pipe oe", 2'b11, port_e_oe[6:5])
    `CHK("pipe level", 2'b10, port_e_out[6:5])
    // Low strobe is driven low, so a falling E with tagging on tags for one cycle.
    tag_enable <= 1'b1;
    e_clock <= 1'b0;
    @(posedge clock);
    #1;
    `CHK("tag low byte", 1'b1, tag_low_byte)
    @(posedge clock);
    #1;
    `CHK("tag pulse end", 1'b0, tag_low_byte)
    stop_test();
  end
endmodule
